// file: hw/bcis_core.sv
// Notes on behaviour
// - power-down sets active-low timeout flag high and clears active-low powerdown flag.
// - power-down zeroes watchdog counter and prescaler; pin-change wake flag unchanged.
// - after power-down the core sleeps and executes nothing until a wake event.
// - file operand is a 5-bit address; destination 0 is accumulator, 1 the file.
// - rotate left through carry as a 9-bit rotation; only carry changes.
// - rotate right through carry as a 9-bit rotation; only carry changes.
// - subtract computes file minus accumulator; updates carry, digit carry and zero.
// - nibble exchange swaps operand halves; no status flag changes.
// - direction load copies accumulator to direction register 6 or 7; flags untouched.
// - xor literal combines 8-bit immediate with accumulator, result into accumulator.
// - xor with file combines accumulator and file; only zero flag changes.
// - move file copies file to destination and updates zero, so it tests a register.
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module bcis_core
    import bcis_pkg::*;
(
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // instruction issue
    input  wire logic       insnValid,
    input  wire logic [3:0] insnOp,
    input  wire logic [4:0] insnFile,
    input  wire logic       insnDest,
    input  wire logic [7:0] insnLit,
    // wake pin
    input  wire logic       pinChange,
    // register port
    input  wire logic [5:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output logic      [7:0] regRdData,
    // core state
    output logic      [7:0] acc,
    output logic            carry,
    output logic            digitCarry,
    output logic            zero,
    output logic            timeoutFlagN,
    output logic            powerdownFlagN,
    output logic            pinChangeWakeFlag,
    output logic      [7:0] watchdogCount,
    output logic            sleeping,
    output logic      [7:0] dirPort6,
    output logic      [7:0] dirPort7
);
    bcis_state_t state;
    logic [7:0]  fileMem [FILE_N];
    logic [7:0]  prescale;
    logic [7:0]  operand;
    logic [7:0]  next_rdData;
    logic        pinSync1;
    logic        pinSync2;
    logic        pinPrev;
    logic        wakeEdge;
    logic        exec;
    logic        execSleep;
    logic        statusWr;
    logic [7:0]  dirPorts [2];

    bcis_alu_if aluBus ();

    // writes a result back to the file space when the destination bit says so
    function automatic logic toFile(input logic [3:0] op, input logic dest);
        logic hasDest;
        hasDest = (op == OP_ROTATE_LEFT_CARRY) || (op == OP_ROTATE_RIGHT_CARRY) ||
                  (op == OP_SUBTRACT_ACC_FROM_FILE) || (op == OP_NIBBLE_EXCHANGE) ||
                  (op == OP_XOR_ACC_WITH_FILE) || (op == OP_MOVE_FILE);
        return hasDest && dest;
    endfunction

    // writes a result into the accumulator
    function automatic logic toAcc(input logic [3:0] op, input logic dest);
        logic hasDest;
        hasDest = (op == OP_ROTATE_LEFT_CARRY) || (op == OP_ROTATE_RIGHT_CARRY) ||
                  (op == OP_SUBTRACT_ACC_FROM_FILE) || (op == OP_NIBBLE_EXCHANGE) ||
                  (op == OP_XOR_ACC_WITH_FILE) || (op == OP_MOVE_FILE);
        return (hasDest && !dest) || (op == OP_XOR_LITERAL_ACC);
    endfunction

    // instructions are only taken while awake; sleep drops them
    assign exec      = insnValid && (state == BCIS_RUN);
    assign execSleep = exec && (insnOp == OP_POWER_DOWN);
    assign statusWr  = regWr && (regAddr == BUS_STATUS);
    assign wakeEdge  = pinSync2 ^ pinPrev;

    // literal or addressed file register feeds the datapath
    assign operand = (insnOp == OP_XOR_LITERAL_ACC) ? insnLit : fileMem[insnFile];

    assign aluBus.opcode  = insnOp;
    assign aluBus.operand = operand;
    assign aluBus.acc     = acc;
    assign aluBus.carryIn = carry;

    bcis_alu u_alu (
        .bus (aluBus)
    );

    // pin is asynchronous: two flops, then a third for change detection
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pinSync1 <= 1'b0;
            pinSync2 <= 1'b0;
            pinPrev  <= 1'b0;
        end else begin
            pinSync1 <= pinChange;
            pinSync2 <= pinSync1;
            pinPrev  <= pinSync2;
        end
    end

    // run and sleep; any pin change wakes the core
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state    <= BCIS_RUN;
            sleeping <= 1'b0;
        end else begin
            unique case (state)
                BCIS_RUN: begin
                    if (execSleep) begin
                        state    <= BCIS_SLEEP;
                        sleeping <= 1'b1;
                    end
                end
                BCIS_SLEEP: begin
                    if (wakeEdge) begin
                        state    <= BCIS_RUN;
                        sleeping <= 1'b0;
                    end
                end
            endcase
        end
    end

    // watchdog: prescaler carries into the counter, power-down clears both
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prescale      <= PRE_CLEAR;
            watchdogCount <= WATCH_CLR;
        end else if (execSleep) begin
            prescale      <= PRE_CLEAR;
            watchdogCount <= WATCH_CLR;
        end else begin
            prescale <= prescale + 8'h01;
            if (prescale == PRE_LAST) begin
                watchdogCount <= watchdogCount + 8'h01;
            end
        end
    end

    // power status flags: only power-down and reset move them here
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            timeoutFlagN   <= 1'b1;
            powerdownFlagN <= 1'b1;
        end else if (execSleep) begin
            timeoutFlagN   <= 1'b1;
            powerdownFlagN <= 1'b0;
        end
    end

    // wake flag: set by a change seen asleep, cleared by writing one; set wins
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pinChangeWakeFlag <= 1'b0;
        end else if ((state == BCIS_SLEEP) && wakeEdge) begin
            pinChangeWakeFlag <= 1'b1;
        end else if (statusWr && regWrData[ST_WAKE]) begin
            pinChangeWakeFlag <= 1'b0;
        end
    end

    // arithmetic flags: an instruction in the same cycle beats a port write
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            carry      <= 1'b0;
            digitCarry <= 1'b0;
            zero       <= 1'b0;
        end else begin
            if (statusWr) begin
                carry      <= regWrData[ST_CARRY];
                digitCarry <= regWrData[ST_DIGIT];
                zero       <= regWrData[ST_ZERO];
            end
            if (exec && aluBus.updCarry) begin
                carry <= aluBus.carryOut;
            end
            if (exec && aluBus.updDigit) begin
                digitCarry <= aluBus.digitOut;
            end
            if (exec && aluBus.updZero) begin
                zero <= aluBus.zeroOut;
            end
        end
    end

    // accumulator
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            acc <= ACC_RST;
        end else if (exec && toAcc(insnOp, insnDest)) begin
            acc <= aluBus.result;
        end
    end

    // file space: port writes first, instruction write-back overrides
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < FILE_N; i++) begin
                fileMem[i] <= FILE_RST;
            end
        end else begin
            if (regWr && !regAddr[5]) begin
                fileMem[regAddr[4:0]] <= regWrData;
            end
            if (exec && toFile(insnOp, insnDest)) begin
                fileMem[insnFile] <= aluBus.result;
            end
        end
    end

    // direction registers; a selector other than 6 or 7 is ignored
    for (genvar g = 0; g < 2; g++) begin : g_dir
        localparam logic [4:0] SEL = (g == 0) ? DIR_FIRST : DIR_SECOND;
        localparam logic [5:0] ADR = (g == 0) ? BUS_DIR6 : BUS_DIR7;
        always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
                dirPorts[g] <= DIR_RST;
            end else if (exec && (insnOp == OP_DIRECTION_LOAD) && (insnFile == SEL)) begin
                dirPorts[g] <= aluBus.result;
            end else if (regWr && (regAddr == ADR)) begin
                dirPorts[g] <= regWrData;
            end
        end
    end

    assign dirPort6 = dirPorts[0];
    assign dirPort7 = dirPorts[1];

    // read mux; unmapped offsets read zero
    always_comb begin
        next_rdData = RD_IDLE;
        if (!regAddr[5]) begin
            next_rdData = fileMem[regAddr[4:0]];
        end else if (regAddr == BUS_STATUS) begin
            next_rdData[ST_CARRY] = carry;
            next_rdData[ST_DIGIT] = digitCarry;
            next_rdData[ST_ZERO]  = zero;
            next_rdData[ST_PWRDN] = powerdownFlagN;
            next_rdData[ST_TMOUT] = timeoutFlagN;
            next_rdData[ST_WAKE]  = pinChangeWakeFlag;
        end else if (regAddr == BUS_WATCHDOG) begin
            next_rdData = watchdogCount;
        end else if (regAddr == BUS_DIR6) begin
            next_rdData = dirPorts[0];
        end else if (regAddr == BUS_DIR7) begin
            next_rdData = dirPorts[1];
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            regRdData <= RD_IDLE;
        end else begin
            regRdData <= regRd ? next_rdData : RD_IDLE;
        end
    end

    // helper terms computed apart from the datapath, for the checks below
    logic       opMsb;
    logic       opLsb;
    logic [6:0] opLow7;
    logic [6:0] opHigh7;
    logic [3:0] opLowNib;
    logic [3:0] opHighNib;
    logic       noBorrow;
    logic       noDigitBorrow;
    logic       subZero;
    logic       xorZero;
    logic       moveZero;
    logic       fileWb;
    assign opMsb         = operand[7];
    assign opLsb         = operand[0];
    assign opLow7        = operand[6:0];
    assign opHigh7       = operand[7:1];
    assign opLowNib      = operand[3:0];
    assign opHighNib     = operand[7:4];
    assign noBorrow      = operand >= acc;
    assign noDigitBorrow = operand[3:0] >= acc[3:0];
    assign subZero       = operand == acc;
    assign xorZero       = (operand ^ acc) == 8'h00;
    assign moveZero      = operand == 8'h00;
    assign fileWb        = exec && toFile(insnOp, insnDest);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_sleep_flags: assert property (execSleep |=> timeoutFlagN && !powerdownFlagN && sleeping)
        else $error("power-down did not set the power status flags");
    a_sleep_watchdog: assert property (execSleep |=> watchdogCount == 8'h00 && prescale == 8'h00)
        else $error("power-down did not clear the watchdog");
    a_sleep_wake_keep: assert property (execSleep && !statusWr |=> $stable(pinChangeWakeFlag))
        else $error("power-down changed the wake flag");
    a_sleep_no_exec: assert property (state == BCIS_SLEEP && !statusWr
        |=> $stable(acc) && $stable(carry))
        else $error("instruction executed while asleep");
    a_dest_file_acc: assert property (fileWb |=> $stable(acc))
        else $error("file destination changed the accumulator");
    a_rotate_left: assert property (exec && insnOp == OP_ROTATE_LEFT_CARRY && !insnDest
        && !statusWr |=> carry == $past(opMsb) && acc == {$past(opLow7), $past(carry)}
            && $stable(zero) && $stable(digitCarry))
        else $error("rotate left result or carry wrong");
    a_rotate_right: assert property (exec && insnOp == OP_ROTATE_RIGHT_CARRY && !insnDest
        && !statusWr |=> carry == $past(opLsb) && acc == {$past(carry), $past(opHigh7)}
            && $stable(zero) && $stable(digitCarry))
        else $error("rotate right result or carry wrong");
    a_subtract_flags: assert property (exec && insnOp == OP_SUBTRACT_ACC_FROM_FILE && !statusWr
        |=> carry == $past(noBorrow) && digitCarry == $past(noDigitBorrow)
            && zero == $past(subZero))
        else $error("subtract flags wrong");
    a_nibble_swap: assert property (exec && insnOp == OP_NIBBLE_EXCHANGE && !insnDest && !statusWr
        |=> acc == {$past(opLowNib), $past(opHighNib)} && $stable(carry) && $stable(zero))
        else $error("nibble exchange wrong");
    a_dir_load: assert property (exec && insnOp == OP_DIRECTION_LOAD && insnFile == DIR_SECOND
        && !statusWr |=> dirPort7 == $past(acc) && $stable(zero) && $stable(carry))
        else $error("direction load wrong");
    a_xor_literal: assert property (exec && insnOp == OP_XOR_LITERAL_ACC
        |=> acc == ($past(acc) ^ $past(insnLit)))
        else $error("xor literal result wrong");
    a_xor_file_flags: assert property (exec && insnOp == OP_XOR_ACC_WITH_FILE && !statusWr
        |=> zero == $past(xorZero) && $stable(carry) && $stable(digitCarry))
        else $error("xor with file flags wrong");
    a_move_test: assert property (exec && insnOp == OP_MOVE_FILE && insnDest && !statusWr
        |=> zero == $past(moveZero) && $stable(acc))
        else $error("move file zero test wrong");
endmodule

// file: common/bcis_pkg.sv
package bcis_pkg;
    // datapath and file space sizes
    localparam int unsigned DATA_W = 8;
    localparam int unsigned FILE_N = 32;
    localparam int unsigned FADR_W = 5;
    localparam int unsigned BADR_W = 6;
    localparam int unsigned OP_W   = 4;
    localparam int unsigned PRE_W  = 8;

    // instruction codes presented on insnOp
    localparam logic [3:0] OP_NOP                    = 4'h0;
    localparam logic [3:0] OP_POWER_DOWN             = 4'h1;
    localparam logic [3:0] OP_ROTATE_LEFT_CARRY      = 4'h2;
    localparam logic [3:0] OP_ROTATE_RIGHT_CARRY     = 4'h3;
    localparam logic [3:0] OP_SUBTRACT_ACC_FROM_FILE = 4'h4;
    localparam logic [3:0] OP_NIBBLE_EXCHANGE        = 4'h5;
    localparam logic [3:0] OP_DIRECTION_LOAD         = 4'h6;
    localparam logic [3:0] OP_XOR_LITERAL_ACC        = 4'h7;
    localparam logic [3:0] OP_XOR_ACC_WITH_FILE      = 4'h8;
    localparam logic [3:0] OP_MOVE_FILE              = 4'h9;

    // register port offsets above the file space
    localparam logic [5:0] BUS_STATUS   = 6'h20;
    localparam logic [5:0] BUS_WATCHDOG = 6'h21;
    localparam logic [5:0] BUS_DIR6     = 6'h22;
    localparam logic [5:0] BUS_DIR7     = 6'h23;

    // status view field positions
    localparam int unsigned ST_CARRY = 0;
    localparam int unsigned ST_DIGIT = 1;
    localparam int unsigned ST_ZERO  = 2;
    localparam int unsigned ST_PWRDN = 3;
    localparam int unsigned ST_TMOUT = 4;
    localparam int unsigned ST_WAKE  = 7;

    // direction register selectors carried in the file field
    localparam logic [4:0] DIR_FIRST  = 5'h06;
    localparam logic [4:0] DIR_SECOND = 5'h07;

    // reset and clear values
    localparam logic [7:0] ACC_RST   = 8'h00;
    localparam logic [7:0] FILE_RST  = 8'h00;
    localparam logic [7:0] DIR_RST   = 8'hFF;
    localparam logic [7:0] WATCH_CLR = 8'h00;
    localparam logic [7:0] PRE_CLEAR = 8'h00;
    localparam logic [7:0] PRE_LAST  = 8'hFF;
    localparam logic [7:0] RD_IDLE   = 8'h00;

    // core run state
    typedef enum logic [1:0] {
        BCIS_RUN   = 2'b01,
        BCIS_SLEEP = 2'b10
    } bcis_state_t;
endpackage

// file: common/bcis_alu_if.sv
`timescale 1ns/10ps
interface bcis_alu_if;
    logic [3:0] opcode;
    logic [7:0] operand;
    logic [7:0] acc;
    logic       carryIn;
    logic [7:0] result;
    logic       carryOut;
    logic       digitOut;
    logic       zeroOut;
    logic       updCarry;
    logic       updDigit;
    logic       updZero;

    modport core (
        output opcode, operand, acc, carryIn,
        input  result, carryOut, digitOut, zeroOut, updCarry, updDigit, updZero
    );
    modport alu (
        input  opcode, operand, acc, carryIn,
        output result, carryOut, digitOut, zeroOut, updCarry, updDigit, updZero
    );
endinterface

// file: hw/bcis_alu.sv
`timescale 1ns/10ps
module bcis_alu
    import bcis_pkg::*;
(
    // operands in, result and flag updates out
    bcis_alu_if.alu bus
);
    logic [8:0] diff;
    logic [4:0] lowDiff;

    // two's complement subtract: carry set means no borrow
    assign diff    = {1'b0, bus.operand} + {1'b0, ~bus.acc} + 9'h001;
    assign lowDiff = {1'b0, bus.operand[3:0]} + {1'b0, ~bus.acc[3:0]} + 5'h01;

    // result and which flags the instruction may touch
    always_comb begin
        bus.result   = bus.operand;
        bus.carryOut = bus.carryIn;
        bus.digitOut = 1'b0;
        bus.updCarry = 1'b0;
        bus.updDigit = 1'b0;
        bus.updZero  = 1'b0;
        unique case (bus.opcode)
            OP_ROTATE_LEFT_CARRY: begin
                bus.result   = {bus.operand[6:0], bus.carryIn};
                bus.carryOut = bus.operand[7];
                bus.updCarry = 1'b1;
            end
            OP_ROTATE_RIGHT_CARRY: begin
                bus.result   = {bus.carryIn, bus.operand[7:1]};
                bus.carryOut = bus.operand[0];
                bus.updCarry = 1'b1;
            end
            OP_SUBTRACT_ACC_FROM_FILE: begin
                bus.result   = diff[7:0];
                bus.carryOut = diff[8];
                bus.digitOut = lowDiff[4];
                bus.updCarry = 1'b1;
                bus.updDigit = 1'b1;
                bus.updZero  = 1'b1;
            end
            OP_NIBBLE_EXCHANGE: begin
                bus.result = {bus.operand[3:0], bus.operand[7:4]};
            end
            OP_DIRECTION_LOAD: begin
                bus.result = bus.acc;
            end
            OP_XOR_LITERAL_ACC, OP_XOR_ACC_WITH_FILE: begin
                bus.result  = bus.acc ^ bus.operand;
                bus.updZero = 1'b1;
            end
            OP_MOVE_FILE: begin
                bus.updZero = 1'b1;
            end
            OP_NOP, OP_POWER_DOWN: begin
                bus.result = bus.operand;
            end
            default: begin
                bus.result = bus.operand;
            end
        endcase
    end

    assign bus.zeroOut = (bus.result == 8'h00);
endmodule

// file: verif/tb.sv
`timescale 1ns/10ps
module tb
    import bcis_pkg::*;
;
    // clock, reset and stimulus
    logic       clk_sys;
    logic       rst;
    logic       insnValid;
    logic [3:0] insnOp;
    logic [4:0] insnFile;
    logic       insnDest;
    logic [7:0] insnLit;
    logic       pinChange;
    logic [5:0] regAddr;
    logic [7:0] regWrData;
    logic       regWr;
    logic       regRd;
    // observed state
    logic [7:0] regRdData;
    logic [7:0] acc;
    logic       carry;
    logic       digitCarry;
    logic       zero;
    logic       timeoutFlagN;
    logic       powerdownFlagN;
    logic       pinChangeWakeFlag;
    logic [7:0] watchdogCount;
    logic       sleeping;
    logic [7:0] dirPort6;
    logic [7:0] dirPort7;
    // bookkeeping
    int         errTotal;
    int         numChecks;
    logic [7:0] rd;

    bcis_core u_bcis_core (
        .clk_sys(clk_sys), .rst(rst), .insnValid(insnValid), .insnOp(insnOp),
        .insnFile(insnFile), .insnDest(insnDest), .insnLit(insnLit),
        .pinChange(pinChange), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .acc(acc),
        .carry(carry), .digitCarry(digitCarry), .zero(zero),
        .timeoutFlagN(timeoutFlagN), .powerdownFlagN(powerdownFlagN),
        .pinChangeWakeFlag(pinChangeWakeFlag), .watchdogCount(watchdogCount),
        .sleeping(sleeping), .dirPort6(dirPort6), .dirPort7(dirPort7)
    );

    // free-running 10 MHz clock
    always #50 clk_sys = ~clk_sys;

    // one value compare; four-state inequality so an unknown never matches
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        numChecks++;
        if (got !== exp) begin
            errTotal++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // flags packed as carry, digit carry, zero in the low bits
    task automatic chkFlags(input logic [2:0] exp);
        chk({5'h00, zero, digitCarry, carry}, {5'h00, exp});
    endtask

    task automatic final_report();
        if (errTotal == 0 && numChecks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // issue one instruction; results are sampled a half cycle after the taking edge
    task automatic exec(input logic [3:0] op, input logic [4:0] f, input logic d,
                        input logic [7:0] lit);
        @(posedge clk_sys);
        insnValid <= 1'b1;
        insnOp    <= op;
        insnFile  <= f;
        insnDest  <= d;
        insnLit   <= lit;
        @(posedge clk_sys);
        insnValid <= 1'b0;
        @(negedge clk_sys);
    endtask

    task automatic regWrite(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regWr     <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge clk_sys);
        regWr     <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic regRead(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRd   <= 1'b0;
        @(negedge clk_sys);
        d = regRdData;
    endtask

    initial begin
        clk_sys = 1'b0; rst = 1'b1; insnValid = 1'b0; insnOp = OP_NOP;
        insnFile = 5'h00; insnDest = 1'b0; insnLit = 8'h00; pinChange = 1'b0;
        regAddr = 6'h00; regWrData = 8'h00; regWr = 1'b0; regRd = 1'b0;
        errTotal = 0; numChecks = 0;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        regWrite(6'h03, 8'hA5);
        regWrite(6'h04, 8'h0F);
        regWrite(6'h1F, 8'h80);
        // literal xor, twice back to zero
        exec(OP_XOR_LITERAL_ACC, 5'h00, 1'b0, 8'h3C); chk(acc, 8'h3C);
        exec(OP_XOR_LITERAL_ACC, 5'h00, 1'b0, 8'h3C); chk(acc, 8'h00);
        chkFlags(3'b100);
        // file xor to each destination
        exec(OP_XOR_ACC_WITH_FILE, 5'h03, 1'b0, 8'h00); chk(acc, 8'hA5);
        chkFlags(3'b000);
        exec(OP_XOR_ACC_WITH_FILE, 5'h03, 1'b1, 8'h00); chk(acc, 8'hA5);
        chkFlags(3'b100);
        regRead(6'h03, rd); chk(rd, 8'h00);
        // rotates through carry, zero held at one to prove it is left alone
        regWrite(BUS_STATUS, 8'h05);
        exec(OP_ROTATE_LEFT_CARRY, 5'h04, 1'b0, 8'h00); chk(acc, 8'h1F);
        chkFlags(3'b100);
        exec(OP_ROTATE_RIGHT_CARRY, 5'h04, 1'b1, 8'h00); chk(acc, 8'h1F);
        chkFlags(3'b101);
        regRead(6'h04, rd); chk(rd, 8'h07);
        // subtract with a full borrow, then an equal pair
        exec(OP_XOR_LITERAL_ACC, 5'h00, 1'b0, 8'h0F); chk(acc, 8'h10);
        exec(OP_SUBTRACT_ACC_FROM_FILE, 5'h04, 1'b0, 8'h00); chk(acc, 8'hF7);
        chkFlags(3'b010);
        regWrite(6'h05, 8'hF7);
        exec(OP_SUBTRACT_ACC_FROM_FILE, 5'h05, 1'b1, 8'h00); chk(acc, 8'hF7);
        chkFlags(3'b111);
        regRead(6'h05, rd); chk(rd, 8'h00);
        // nibble exchange and direction loads keep every flag
        regWrite(6'h06, 8'h3C);
        exec(OP_NIBBLE_EXCHANGE, 5'h06, 1'b0, 8'h00); chk(acc, 8'hC3);
        chkFlags(3'b111);
        exec(OP_DIRECTION_LOAD, DIR_FIRST, 1'b0, 8'h00); chk(dirPort6, 8'hC3);
        chk(dirPort7, 8'hFF);
        chkFlags(3'b111);
        exec(OP_XOR_LITERAL_ACC, 5'h00, 1'b0, 8'hFF); chk(acc, 8'h3C);
        exec(OP_DIRECTION_LOAD, DIR_SECOND, 1'b0, 8'h00); chk(dirPort7, 8'h3C);
        regRead(BUS_DIR7, rd); chk(rd, 8'h3C);
        // a selector other than 6 or 7 loads nothing
        exec(OP_DIRECTION_LOAD, 5'h05, 1'b0, 8'h00); chk(dirPort6, 8'hC3);
        chk(dirPort7, 8'h3C);
        // no-op and an unused code leave accumulator and flags alone
        exec(OP_NOP, 5'h03, 1'b0, 8'hFF); chk(acc, 8'h3C);
        exec(4'hF, 5'h03, 1'b0, 8'hFF); chk(acc, 8'h3C);
        chkFlags(3'b011);
        // move file as a register test, and the top file address
        exec(OP_MOVE_FILE, 5'h03, 1'b1, 8'h00); chk(acc, 8'h3C);
        chkFlags(3'b111);
        exec(OP_MOVE_FILE, 5'h1F, 1'b0, 8'h00); chk(acc, 8'h80);
        chkFlags(3'b011);
        // unmapped place ignores writes and reads zero
        regWrite(6'h3F, 8'hFF);
        regRead(6'h3F, rd); chk(rd, 8'h00);
        // let the watchdog advance so its clearing is visible
        repeat (300) @(posedge clk_sys);
        @(negedge clk_sys);
        chk({7'h00, |watchdogCount}, 8'h01);
        exec(OP_POWER_DOWN, 5'h00, 1'b0, 8'h00); chk(sleeping, 1'b1);
        chk(timeoutFlagN, 1'b1);
        chk(powerdownFlagN, 1'b0);
        chk(watchdogCount, WATCH_CLR);
        chk(pinChangeWakeFlag, 1'b0);
        regRead(BUS_WATCHDOG, rd); chk(rd, 8'h00);
        // instructions while asleep are not executed
        exec(OP_XOR_LITERAL_ACC, 5'h00, 1'b0, 8'hFF); chk(acc, 8'h80);
        chk(sleeping, 1'b1);
        // wake by pin change, bounded wait
        @(posedge clk_sys);
        pinChange <= 1'b1;
        for (int i = 0; i < 12 && sleeping !== 1'b0; i++) begin
            @(negedge clk_sys);
        end
        if (sleeping !== 1'b0) begin
            errTotal++;
            $display("MISMATCH t=%0t no wake from pin change", $time);
        end else begin
            chk(pinChangeWakeFlag, 1'b1);
            // a second power-down must leave the wake flag standing
            exec(OP_POWER_DOWN, 5'h00, 1'b0, 8'h00); chk(pinChangeWakeFlag, 1'b1);
            regRead(BUS_STATUS, rd); chk(rd, 8'h93);
            // writing one to the wake bit clears it; power bits stay read-only
            regWrite(BUS_STATUS, 8'h8B);
            regRead(BUS_STATUS, rd); chk(rd, 8'h13);
        end
        final_report();
    end
endmodule
